// ===== sfscmd_pkg.sv
// Purpose: Shared constants and types of the serial flash status-write and read command block
// Assumes: System clock of 200 MHz, link clock from the host
// Notes:   Opcodes, status bit positions, phase lengths and the write cycle time
package sfscmd_pkg;

  // ************************************************************
  // Opcodes
  // ************************************************************
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;

  // ************************************************************
  // Status register layout and reset values
  // ************************************************************
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  localparam int ST_BP_LSB = 2;
  localparam int ST_BP_MSB = 5;
  localparam int ST_PIN_DIS = 6;
  localparam int ST_PROT = 7;
  localparam logic [3:0] RST_BP = 4'h0;
  localparam logic RST_PROT = 1'h0;
  localparam logic RST_OTP_LOCK = 1'h0;
  localparam logic RST_WEL = 1'h0;

  // ************************************************************
  // Frame lengths in link clocks (LAST counts are last index; frame bit counts and the data field end are totals)
  // ************************************************************
  localparam logic [4:0] CMD_LAST = 5'h07;
  localparam logic [4:0] WRITE_ENABLE_CMD_FRAME_BITS = 5'h08;
  localparam logic [4:0] STATUS_WRITE_CMD_FRAME_BITS = 5'h10;
  localparam logic [4:0] DATA_FIELD_END = 5'h10;
  localparam logic [4:0] ADDR_LAST_SINGLE = 5'h17;
  localparam logic [4:0] ADDR_LAST_DUAL = 5'h0B;
  localparam logic [4:0] DUMMY_LAST_FAST = 5'h07;
  localparam logic [4:0] DUMMY_LAST_DIO = 5'h03;
  localparam logic [4:0] BYTE_LAST_SINGLE = 5'h07;
  localparam logic [4:0] BYTE_LAST_DUAL = 5'h03;
  localparam logic [4:0] CNT_MAX = 5'h1F;

  // ************************************************************
  // Self-timed status write cycle
  // ************************************************************
  localparam int SYS_PERIOD_NS = 5;
  localparam int T_W_NS = 10000;
  localparam int T_W_CYC = (T_W_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam logic [11:0] T_W_COUNT = 12'(T_W_CYC);

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    SFS_CMD = 3'h0,
    SFS_ADDR = 3'h1,
    SFS_DUMMY = 3'h2,
    SFS_DATA = 3'h3,
    SFS_IGNORE = 3'h4
  } sfscmd_state_t;

  typedef enum logic [1:0] {
    RK_READ = 2'h0,
    RK_FAST = 2'h1,
    RK_DOUT = 2'h2,
    RK_DIO = 2'h3
  } sfscmd_kind_t;

endpackage

// ===== sfscmd_top.sv
// Purpose: Status-write and read command handling of a serial flash device
// Assumes: SCK runs only while CS_N is low; memory array answers MEM_RDATA for MEM_ADDR on the link clock
// Notes:   Overview of operation
// Overview of operation
// - Status write needs write-enable latch set
// - Status write keeps busy and latch bits
// - Select must rise right after eighth bit
// - Busy held high during self-timed write
// - Latch cleared when write cycle ends
// - Status reads answered while cycle runs
// - Status write updates protect field, protect bit
// - Hardware protected mode refuses status writes
// - OTP mode sets lock bit, ignores data
// - Read takes 24-bit address on rising edges
// - Data shifted out on falling edges
// - Address increments per byte, wraps to zero
// - Select high stops output immediately
// - Reads rejected while a cycle runs
// - Fast read has one dummy byte
// - Dual output read drives two lines
// - Dual output read: eight ignored dummy clocks
// - Dual I/O address two bits per clock
// - Dual I/O address, dummy, data two-bit
// - Write-enable command sets the latch
// - Protect bit plus low pin: hardware protected
// - Pin disable bit ignores protect pin
module sfscmd_top (
  // System clock and reset
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Serial link
  input wire logic SCK,
  input wire logic CS_N,
  input wire logic IO0_I,
  output logic IO0_O,
  output logic IO0_OE_N,
  input wire logic IO1_I,
  output logic IO1_O,
  output logic IO1_OE_N,
  input wire logic WP_N,
  // Memory array read port
  output logic [23:0] MEM_ADDR,
  input wire logic [7:0] MEM_RDATA,
  // Control from neighbouring logic
  input wire logic OTP_MODE,
  input wire logic EXT_BUSY,
  input wire logic PROTECT_PIN_DISABLE_BIT,
  // Status
  output logic [7:0] STATUS,
  output logic HW_PROTECT
);

  // ************************************************************
  // Link domain: frame decode on rising SCK
  // ************************************************************
  logic link_rst;
  sfscmd_pkg::sfscmd_state_t state;
  sfscmd_pkg::sfscmd_kind_t kind;
  logic status_rd;
  logic [4:0] cnt;
  logic [4:0] pc;
  logic [23:0] addr;
  logic [7:0] op;
  logic [7:0] wr_byte;
  logic [4:0] held_cnt;
  logic tog;
  logic [7:0] st_l1;
  logic [7:0] st_l2;
  logic [7:0] op_now;
  logic [4:0] cnt_inc;
  logic dual_out;
  logic [4:0] byte_last;
  logic busy_l;

  // Select high ends the frame at once, with no SCK edge needed
  assign link_rst = ~RSTN | CS_N;
  assign op_now = {op[6:0], IO0_I};
  assign cnt_inc = (cnt == sfscmd_pkg::CNT_MAX) ? cnt : cnt + 5'h01;
  assign dual_out = ~status_rd & (kind == sfscmd_pkg::RK_DOUT || kind == sfscmd_pkg::RK_DIO);
  assign byte_last = dual_out ? sfscmd_pkg::BYTE_LAST_DUAL : sfscmd_pkg::BYTE_LAST_SINGLE;
  assign busy_l = st_l2[sfscmd_pkg::ST_BUSY];
  assign MEM_ADDR = addr;

  // Status bits are independent levels; SCK stops between frames, so the copy is
  // refreshed only after two edges of a new frame, well before the opcode ends
  always_ff @(posedge SCK or negedge RSTN) begin
    if (!RSTN) begin
      st_l1 <= 8'h00;
      st_l2 <= 8'h00;
    end else begin
      st_l1 <= STATUS;
      st_l2 <= st_l1;
    end
  end

  // Opcode, data byte and bit count survive select rising so the system side can judge the frame
  always_ff @(posedge SCK or negedge RSTN) begin
    if (!RSTN) begin
      op <= 8'h00;
      wr_byte <= 8'h00;
      held_cnt <= 5'h00;
      tog <= 1'h0;
    end else begin
      if (cnt <= sfscmd_pkg::CMD_LAST) begin
        op <= op_now;
      end else if (cnt < sfscmd_pkg::DATA_FIELD_END) begin
        wr_byte <= {wr_byte[6:0], IO0_I};
      end
      held_cnt <= cnt_inc;
      if (cnt == 5'h00) begin
        tog <= ~tog;
      end
    end
  end

  always_ff @(posedge SCK or posedge link_rst) begin
    if (link_rst) begin
      state <= sfscmd_pkg::SFS_CMD;
      kind <= sfscmd_pkg::RK_READ;
      status_rd <= 1'h0;
      cnt <= 5'h00;
      pc <= 5'h00;
      addr <= 24'h000000;
    end else begin
      cnt <= cnt_inc;
      case (state)
        sfscmd_pkg::SFS_CMD: begin
          if (cnt == sfscmd_pkg::CMD_LAST) begin
            pc <= 5'h00;
            case (op_now)
              sfscmd_pkg::OP_READ: begin
                kind <= sfscmd_pkg::RK_READ;
                state <= busy_l ? sfscmd_pkg::SFS_IGNORE : sfscmd_pkg::SFS_ADDR;
              end
              sfscmd_pkg::OP_FAST_READ: begin
                kind <= sfscmd_pkg::RK_FAST;
                state <= busy_l ? sfscmd_pkg::SFS_IGNORE : sfscmd_pkg::SFS_ADDR;
              end
              sfscmd_pkg::OP_DUAL_OUT_READ: begin
                kind <= sfscmd_pkg::RK_DOUT;
                state <= busy_l ? sfscmd_pkg::SFS_IGNORE : sfscmd_pkg::SFS_ADDR;
              end
              sfscmd_pkg::OP_DUAL_IO_READ: begin
                kind <= sfscmd_pkg::RK_DIO;
                state <= busy_l ? sfscmd_pkg::SFS_IGNORE : sfscmd_pkg::SFS_ADDR;
              end
              sfscmd_pkg::OP_STATUS_READ: begin
                status_rd <= 1'h1;
                state <= sfscmd_pkg::SFS_DATA;
              end
              default: begin
                state <= sfscmd_pkg::SFS_IGNORE;
              end
            endcase
          end
        end
        sfscmd_pkg::SFS_ADDR: begin
          pc <= pc + 5'h01;
          if (kind == sfscmd_pkg::RK_DIO) begin
            addr <= {addr[21:0], IO1_I, IO0_I};
            if (pc == sfscmd_pkg::ADDR_LAST_DUAL) begin
              pc <= 5'h00;
              state <= sfscmd_pkg::SFS_DUMMY;
            end
          end else begin
            addr <= {addr[22:0], IO0_I};
            if (pc == sfscmd_pkg::ADDR_LAST_SINGLE) begin
              pc <= 5'h00;
              state <= (kind == sfscmd_pkg::RK_READ) ? sfscmd_pkg::SFS_DATA : sfscmd_pkg::SFS_DUMMY;
            end
          end
        end
        sfscmd_pkg::SFS_DUMMY: begin
          // Inputs are don't-care here
          pc <= pc + 5'h01;
          if (kind == sfscmd_pkg::RK_DIO && pc == sfscmd_pkg::DUMMY_LAST_DIO) begin
            pc <= 5'h00;
            state <= sfscmd_pkg::SFS_DATA;
          end else if (kind != sfscmd_pkg::RK_DIO && pc == sfscmd_pkg::DUMMY_LAST_FAST) begin
            pc <= 5'h00;
            state <= sfscmd_pkg::SFS_DATA;
          end
        end
        sfscmd_pkg::SFS_DATA: begin
          if (pc == byte_last) begin
            pc <= 5'h00;
            if (!status_rd) begin
              addr <= addr + 24'h000001;
            end
          end else begin
            pc <= pc + 5'h01;
          end
        end
        sfscmd_pkg::SFS_IGNORE: begin
          pc <= 5'h00;
        end
        default: begin
          state <= sfscmd_pkg::SFS_IGNORE;
        end
      endcase
    end
  end

  // ************************************************************
  // Link domain: data out on falling SCK
  // ************************************************************
  logic [7:0] sh;
  logic [7:0] cur;

  always_comb begin
    cur = sh;
    if (pc == 5'h00) begin
      cur = status_rd ? st_l2 : MEM_RDATA;
    end
  end

  always_ff @(negedge SCK or posedge link_rst) begin
    if (link_rst) begin
      IO0_O <= 1'h0;
      IO1_O <= 1'h0;
      IO0_OE_N <= 1'h1;
      IO1_OE_N <= 1'h1;
      sh <= 8'h00;
    end else if (state == sfscmd_pkg::SFS_DATA) begin
      if (dual_out) begin
        IO1_O <= cur[7];
        IO0_O <= cur[6];
        IO0_OE_N <= 1'h0;
        IO1_OE_N <= 1'h0;
        sh <= {cur[5:0], 2'h0};
      end else begin
        IO1_O <= cur[7];
        IO1_OE_N <= 1'h0;
        IO0_OE_N <= 1'h1;
        sh <= {cur[6:0], 1'h0};
      end
    end else begin
      IO0_OE_N <= 1'h1;
      IO1_OE_N <= 1'h1;
    end
  end

  // ************************************************************
  // System domain: frame commit and status register
  // ************************************************************
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic tog_s1;
  logic tog_s2;
  logic tog_seen;
  logic wp_s1;
  logic wp_s2;
  logic commit;
  logic write_enable_cmd_hit;
  logic status_write_cmd_seen;
  logic status_write_cmd_hit;
  logic hardware_protected_mode;
  logic busy;
  logic wr_end;
  logic wr_cyc;
  logic [11:0] wr_cnt;
  logic [7:0] wr_data;
  logic write_enable_latch;
  logic [3:0] bp;
  logic prot;
  logic otp_lock;
  logic [7:0] next_status;

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cs_s1 <= 1'h1;
      cs_s2 <= 1'h1;
      cs_s3 <= 1'h1;
      tog_s1 <= 1'h0;
      tog_s2 <= 1'h0;
      tog_seen <= 1'h0;
      wp_s1 <= 1'h1;
      wp_s2 <= 1'h1;
    end else begin
      cs_s1 <= CS_N;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
      tog_s1 <= tog;
      tog_s2 <= tog_s1;
      wp_s1 <= WP_N;
      wp_s2 <= wp_s1;
      if (cs_s2 && !cs_s3) begin
        tog_seen <= tog_s2;
      end
    end
  end

  // Frame words are stable from select rising until the next frame clocks, so they are
  // read here only under the synchronised select edge; a frame without clocks commits nothing
  assign commit = cs_s2 & ~cs_s3 & (tog_s2 != tog_seen);
  assign write_enable_cmd_hit = commit & (op == sfscmd_pkg::OP_WRITE_ENABLE) & (held_cnt == sfscmd_pkg::WRITE_ENABLE_CMD_FRAME_BITS);
  assign status_write_cmd_seen = commit & (op == sfscmd_pkg::OP_STATUS_WRITE) & (held_cnt == sfscmd_pkg::STATUS_WRITE_CMD_FRAME_BITS);
  assign hardware_protected_mode = prot & ~wp_s2 & ~PROTECT_PIN_DISABLE_BIT;
  assign busy = wr_cyc | EXT_BUSY;
  assign status_write_cmd_hit = status_write_cmd_seen & write_enable_latch & ~busy & ~hardware_protected_mode;
  assign wr_end = wr_cyc & (wr_cnt == 12'h001);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      wr_cyc <= 1'h0;
      wr_cnt <= 12'h000;
      wr_data <= 8'h00;
    end else if (status_write_cmd_hit) begin
      wr_cyc <= 1'h1;
      wr_cnt <= sfscmd_pkg::T_W_COUNT;
      wr_data <= wr_byte;
    end else if (wr_cyc) begin
      wr_cnt <= wr_cnt - 12'h001;
      if (wr_end) begin
        wr_cyc <= 1'h0;
      end
    end
  end

  // Set wins over the end-of-cycle clear
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      write_enable_latch <= sfscmd_pkg::RST_WEL;
    end else if (write_enable_cmd_hit) begin
      write_enable_latch <= 1'h1;
    end else if (wr_end) begin
      write_enable_latch <= 1'h0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      bp <= sfscmd_pkg::RST_BP;
      prot <= sfscmd_pkg::RST_PROT;
      otp_lock <= sfscmd_pkg::RST_OTP_LOCK;
    end else if (wr_end) begin
      if (OTP_MODE) begin
        otp_lock <= 1'h1;
      end else begin
        bp <= wr_data[sfscmd_pkg::ST_BP_MSB:sfscmd_pkg::ST_BP_LSB];
        prot <= wr_data[sfscmd_pkg::ST_PROT];
      end
    end
  end

  // Low two bits never come from the written byte
  always_comb begin
    next_status = 8'h00;
    next_status[sfscmd_pkg::ST_BUSY] = busy;
    next_status[sfscmd_pkg::ST_WEL] = write_enable_latch;
    next_status[sfscmd_pkg::ST_BP_MSB:sfscmd_pkg::ST_BP_LSB] = bp;
    next_status[sfscmd_pkg::ST_PIN_DIS] = PROTECT_PIN_DISABLE_BIT;
    next_status[sfscmd_pkg::ST_PROT] = OTP_MODE ? otp_lock : prot;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      STATUS <= 8'h00;
      HW_PROTECT <= 1'h0;
    end else begin
      STATUS <= next_status;
      HW_PROTECT <= hardware_protected_mode;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  a_write_enable_cmd_sets_latch: assert property (@(posedge SYS_CLK) disable iff (!RSTN) write_enable_cmd_hit |=> write_enable_latch ##1 STATUS[1])
    else $error("write enable did not set latch");
  a_write_needs_latch: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (status_write_cmd_seen && !write_enable_latch && !wr_cyc) |=> !wr_cyc)
    else $error("status write started without latch");
  a_frame_length: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (commit && op == sfscmd_pkg::OP_STATUS_WRITE && held_cnt != sfscmd_pkg::STATUS_WRITE_CMD_FRAME_BITS && !wr_cyc) |=> !wr_cyc)
    else $error("status write of wrong length executed");
  a_busy_visible: assert property (@(posedge SYS_CLK) disable iff (!RSTN) $rose(wr_cyc) |=> STATUS[0] [*8])
    else $error("busy bit not shown during write cycle");
  a_latch_clears: assert property (@(posedge SYS_CLK) disable iff (!RSTN) (wr_end && !write_enable_cmd_hit) |=> !write_enable_latch ##1 !STATUS[1])
    else $error("latch not cleared at cycle end");
  a_protect_update: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (wr_end && !OTP_MODE) |=> (bp == wr_data[5:2]) && (prot == wr_data[7]))
    else $error("protect bits not updated");
  a_hpm_refuses: assert property (@(posedge SYS_CLK) disable iff (!RSTN) (commit && hardware_protected_mode && !wr_cyc) |=> !wr_cyc)
    else $error("status write ran in hardware protected mode");
  a_otp_lock_set: assert property (@(posedge SYS_CLK) disable iff (!RSTN)
    (wr_end && OTP_MODE) |=> otp_lock && (bp == $past(bp)))
    else $error("lock bit not set or data used in OTP mode");
  a_read_reject: assert property (@(posedge SCK) disable iff (link_rst)
    (state == sfscmd_pkg::SFS_CMD && cnt == sfscmd_pkg::CMD_LAST && busy_l && op_now == sfscmd_pkg::OP_READ)
    |=> state == sfscmd_pkg::SFS_IGNORE)
    else $error("read accepted while busy");
  a_dio_dummy_len: assert property (@(posedge SCK) disable iff (link_rst)
    (state == sfscmd_pkg::SFS_ADDR && kind == sfscmd_pkg::RK_DIO && pc == sfscmd_pkg::ADDR_LAST_DUAL)
    |=> (state == sfscmd_pkg::SFS_DUMMY) [*4] ##1 state == sfscmd_pkg::SFS_DATA)
    else $error("dual I/O dummy phase not four clocks");
  a_addr_wrap: assert property (@(posedge SCK) disable iff (link_rst)
    (state == sfscmd_pkg::SFS_DATA && !status_rd && pc == byte_last && addr == 24'hFFFFFF) |=> addr == 24'h000000)
    else $error("address did not wrap to zero");

endmodule // sfscmd_top

// ===== sfscmd_host.sv
// Purpose: SPI host model for the serial flash command block
// Assumes: Mode 0, link clock low and still outside frames, 80 ns period
// Notes:   Lines the host has released show a changing pattern, never the old value
module sfscmd_host (
  // Link lines driven by the host
  output logic sck,
  output logic cs_n,
  output logic io0,
  output logic io1,
  // Resolved data lines
  input wire logic dq0,
  input wire logic dq1
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 40;
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io0 = 1'b0;
    io1 = 1'b0;
  end
  // Odd offset keeps link edges away from the system clock edges
  task automatic start;
    #1.37;
    cs_n = 1'b0;
    #HALF;
  endtask
  // Select rises HALF after the last clock, on any bit count; quick ends a read at once
  task automatic stop(input logic quick = 1'b0);
    if (!quick) begin
      #HALF;
    end
    cs_n = 1'b1;
    io0 = ~io0;
    io1 = ~io1;
    #(3*HALF);
  endtask
  // One clock: lines set while low, both sampled at the rising edge
  task automatic clk(input logic b1, input logic b0, output logic [1:0] r);
    io1 = b1;
    io0 = b0;
    #(HALF/2);
    sck = 1'b1;
    r = {dq1, dq0};
    #HALF;
    sck = 1'b0;
    #(HALF/2);
  endtask
  // Opcode, address or data byte, MSB first on line 0
  task automatic send(input logic [7:0] b, input int n = 8);
    logic [1:0] r;
    for (int i = 7; i > 7 - n; i--) begin
      clk(~io1, b[i], r);
    end
  endtask
  // Address two bits per clock, A23:A22 first
  task automatic send_dual(input logic [23:0] a);
    logic [1:0] r;
    for (int i = 11; i >= 0; i--) begin
      clk(a[2*i+1], a[2*i], r);
    end
  endtask
  // Dummy clocks with both input lines released
  task automatic dummy(input int n);
    logic [1:0] r;
    repeat (n) clk(~io1, ~io0, r);
  endtask
  // One byte back: single on line 1, or two bits per clock
  task automatic recv(input logic dual, output logic [7:0] d);
    logic [1:0] r;
    for (int i = 0; i < (dual ? 4 : 8); i++) begin
      clk(~io1, ~io0, r);
      d = dual ? {d[5:0], r} : {d[6:0], r[1]};
    end
  endtask
endmodule // sfscmd_host

// ===== sfscmd_top_tb_top.sv
// Purpose: Self-checking bench of the status-write and read command block
// Assumes: Memory array modelled as a fixed function of the address
// Notes:   Write cycle waits use the package cycle count alone, with no added margin
module sfscmd_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rstn, otp_mode, ext_busy, pin_dis, wp_n;
  logic sck, cs_n, h_io0, h_io1, dq0, dq1;
  logic io0_o, io0_oe_n, io1_o, io1_oe_n, hw_protect;
  logic [23:0] mem_addr;
  logic [7:0] mem_rdata, status;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  assign dq0 = io0_oe_n ? h_io0 : io0_o;
  assign dq1 = io1_oe_n ? h_io1 : io1_o;
  assign mem_rdata = mem_addr[7:0] ^ 8'hA5;
  sfscmd_top u_dut (.SYS_CLK(sys_clk), .RSTN(rstn), .SCK(sck), .CS_N(cs_n), .IO0_I(dq0), .IO0_O(io0_o),
    .IO0_OE_N(io0_oe_n), .IO1_I(dq1), .IO1_O(io1_o), .IO1_OE_N(io1_oe_n), .WP_N(wp_n), .MEM_ADDR(mem_addr),
    .MEM_RDATA(mem_rdata), .OTP_MODE(otp_mode), .EXT_BUSY(ext_busy), .PROTECT_PIN_DISABLE_BIT(pin_dis),
    .STATUS(status), .HW_PROTECT(hw_protect));
  sfscmd_host u_host (.sck(sck), .cs_n(cs_n), .io0(h_io0), .io1(h_io1), .dq0(dq0), .dq1(dq1));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // Whole run needs about 13000 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_fail++;
      $display("ERROR timeout expected 0 seen %0d", cycles);
      test_done();
    end
  end
  function automatic logic [7:0] mem_of(input logic [23:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic sys_wait(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.start();
    u_host.send(op);
    u_host.stop();
  endtask
  task automatic write_status(input logic [7:0] d, input int n = 8);
    u_host.start();
    u_host.send(sfscmd_pkg::OP_STATUS_WRITE);
    u_host.send(d, n);
    u_host.stop();
  endtask
  // Read of any kind; when refused no line may turn to output
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n, input logic busy);
    logic [7:0] d;
    logic dual;
    dual = (op == sfscmd_pkg::OP_DUAL_OUT_READ) || (op == sfscmd_pkg::OP_DUAL_IO_READ);
    u_host.start();
    u_host.send(op);
    if (op == sfscmd_pkg::OP_DUAL_IO_READ) begin
      u_host.send_dual(a);
      u_host.dummy(4);
    end else begin
      for (int k = 2; k >= 0; k--) begin
        u_host.send(a[8*k+:8]);
      end
      u_host.dummy(op == sfscmd_pkg::OP_READ ? 0 : 8);
    end
    for (int i = 0; i < n; i++) begin
      u_host.recv(dual, d);
      if (!busy) begin
        cmp("read byte", mem_of(a + 24'(i)), d);
      end
    end
    cmp_bit("line 0 enable", busy | !dual, io0_oe_n);
    cmp_bit("line 1 enable", busy, io1_oe_n);
    u_host.send(8'h00, 3);
    u_host.stop(1'b1);
    cmp_bit("line 1 enable after select", 1'b1, io1_oe_n);
  endtask
  task automatic t_wel;
    cmp("status after reset", 8'h00, status);
    write_status(8'hFC);
    cmp("status without latch", 8'h00, status);
    cmd(sfscmd_pkg::OP_WRITE_ENABLE);
    cmp("status after enable", 8'h02, status);
    write_status(8'hFC, 7);
    cmp("status after short frame", 8'h02, status);
  endtask
  task automatic t_write;
    logic [7:0] s;
    write_status(8'hFF);
    cmp("status in cycle", 8'h03, status);
    u_host.start();
    u_host.send(sfscmd_pkg::OP_STATUS_READ);
    u_host.recv(1'b0, s);
    u_host.stop();
    cmp("status read in cycle", 8'h03, s);
    rd(sfscmd_pkg::OP_READ, 24'h000000, 1, 1'b1);
    sys_wait(sfscmd_pkg::T_W_CYC);
    cmp("status after cycle", 8'hBC, status);
  endtask
  task automatic t_protect;
    wp_n = 1'b0;
    sys_wait(6);
    cmp_bit("hardware protect", 1'b1, hw_protect);
    cmd(sfscmd_pkg::OP_WRITE_ENABLE);
    write_status(8'h00);
    cmp("status when protected", 8'hBE, status);
    sys_wait(1);
    pin_dis = 1'b1;
    sys_wait(6);
    cmp_bit("hardware protect pin off", 1'b0, hw_protect);
    write_status(8'h00);
    sys_wait(sfscmd_pkg::T_W_CYC);
    cmp("status pin off", 8'h40, status);
    pin_dis = 1'b0;
    wp_n = 1'b1;
  endtask
  task automatic t_otp;
    otp_mode = 1'b1;
    cmd(sfscmd_pkg::OP_WRITE_ENABLE);
    write_status(8'h00);
    sys_wait(sfscmd_pkg::T_W_CYC);
    cmp("status in one-time mode", 8'h80, status);
    otp_mode = 1'b0;
  endtask
  task automatic t_reads;
    rd(sfscmd_pkg::OP_READ, 24'hFFFFFE, 3, 1'b0);
    rd(sfscmd_pkg::OP_FAST_READ, 24'h000010, 2, 1'b0);
    rd(sfscmd_pkg::OP_DUAL_OUT_READ, 24'h0000FF, 2, 1'b0);
    rd(sfscmd_pkg::OP_DUAL_IO_READ, 24'h000123, 2, 1'b0);
    sys_wait(1);
    ext_busy = 1'b1;
    sys_wait(4);
    rd(sfscmd_pkg::OP_DUAL_IO_READ, 24'h000040, 1, 1'b1);
    sys_wait(1);
    ext_busy = 1'b0;
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    otp_mode = 1'b0;
    ext_busy = 1'b0;
    pin_dis = 1'b0;
    wp_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    rstn = 1'b1;
    sys_wait(4);
    t_wel();
    t_write();
    t_protect();
    t_otp();
    t_reads();
    test_done();
  end
endmodule // sfscmd_top_tb_top
